// [core/eirq_pkg.sv]
// Package of constants and carrier types for the interrupt front end
// Overview of operation
// - Select zero: vectors at program memory start
// - Boot base comes from boot size fuses
// - Select write counts only within unlock window
// - Unlock blocks interrupts until after select write
// - No select write: block lasts four cycles
// - Blocking leaves global enable bit untouched
// - Boot vectors, app lock: mute in application
// - App vectors, boot lock: mute in boot
// - Unlock bit self-clears after four cycles
// - Pin level detected even when driven out
// - Groups two/one/zero cover inputs 23:16/15:8/7:0
// - Only masked-in inputs feed a group
// - Pin change detection needs no I/O clock
// - Low, any change, falling or rising per pin; two registers
// - Level mode requests while pin stays low
// - Pins 7:4 edges only on I/O clock
// - Low level and pins 3:0 edges asynchronous
// - I/O clock stops in all sleep except idle
// - Level lost before start-up: wake, no interrupt
// - Reset fuse, 8K boot: start at 0x1F000
// - Sense code 00 low, 01 any, 10 fall, 11 rise
// - Flag set on edge, clear by ack or one-write
// - Delivery needs mask bit and global enable
package eirq_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W   = 17;
  localparam logic [ADDR_W-1:0] OFS_MCU_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SENSE_LOW   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SENSE_HIGH  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_MASK        = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_FLAG        = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_PC_CTRL     = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_PC_MASK0    = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_PC_MASK1    = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_PC_MASK2    = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_PC_FLAG     = 12'h024;
  localparam int unsigned BIT_UNLOCK = 0;
  localparam int unsigned BIT_SELECT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int unsigned UNLOCK_CYCLES = 4;
  localparam logic [2:0] UNLOCK_LAST = 3'h4;
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // Boot section word start for each boot size fuse code (11 smallest)
  localparam logic [PC_W-1:0] BOOT_BASE_00 = 17'h1F000;
  localparam logic [PC_W-1:0] BOOT_BASE_01 = 17'h1F800;
  localparam logic [PC_W-1:0] BOOT_BASE_10 = 17'h1FC00;
  localparam logic [PC_W-1:0] BOOT_BASE_11 = 17'h1FE00;
  localparam logic [PC_W-1:0] APP_BASE     = 17'h00000;
  localparam logic [5:0] VEC_PC0 = 6'h09;

  typedef struct packed {
    logic            valid;
    logic [5:0]      index;
    logic [PC_W-1:0] addr;
  } eirq_req_type;

  typedef struct packed {
    logic            pc_in_boot;
    logic            global_enable;
    logic            io_clk_run;
    logic            ack;
    logic [5:0]      ack_index;
  } eirq_core_type;
endpackage : eirq_pkg

// [core/eirq_sync.sv]
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module eirq_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : eirq_sync

// [core/eirq_top.sv]
// Interrupt front end: vector placement, external and pin change requests
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module eirq_top (
  // APB slave
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [eirq_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Pins
  input  wire logic [7:0]                   ext_irq_pins,
  input  wire logic [23:0]                  pin_change_inputs,
  // Fuses and lock bits
  input  wire logic [1:0]                   boot_size_fuses,
  input  wire logic                         boot_reset_location_fuse,
  input  wire logic                         app_side_lock_bit,
  input  wire logic                         boot_side_lock_bit,
  // Core side
  input  wire eirq_pkg::eirq_core_type      core_in,
  output eirq_pkg::eirq_req_type            core_req,
  output logic                              wake_request,
  output logic [eirq_pkg::PC_W-1:0]         reset_vector
);
  import eirq_pkg::*;

  function automatic logic [PC_W-1:0] vec_addr(input logic [PC_W-1:0] base,
                                               input logic [5:0] idx);
    vec_addr = base + {10'h000, idx, 1'b0};
  endfunction : vec_addr

  logic [7:0]  ext_s;
  logic [7:0]  ext_s_n;
  logic [23:0] pc_s;
  logic [7:0]  ext_d;
  logic [23:0] pc_d;
  logic        vector_base_select;
  logic        vector_change_unlock;
  logic [2:0]  unlock_cnt;
  logic        block_tail;
  logic [7:0]  sense_ctrl_low_pins;
  logic [7:0]  sense_ctrl_high_pins;
  logic [7:0]  ext_irq_mask_reg;
  logic [7:0]  ext_irq_flag_reg;
  logic [2:0]  pc_enable;
  logic [7:0]  pin_change_mask_zero;
  logic [7:0]  pin_change_mask_one;
  logic [7:0]  pin_change_mask_two;
  logic [2:0]  pc_flag;
  logic [7:0]  edge_hit;
  logic [7:0]  level_req;
  logic [2:0]  pc_hit;
  logic [15:0] sense_all;
  logic        wr;
  logic        rd;
  logic        irq_blocked;
  logic        sect_mute;
  logic [PC_W-1:0] boot_base;
  logic [PC_W-1:0] vec_base;
  logic [10:0] pending;
  logic [5:0]  next_index;
  logic        next_valid;

  // Pins are sampled through two flops; the pin level is read even when
  // the port drives it, so software can raise its own requests.
  // External pins idle high, so they travel inverted: the cleared
  // synchroniser then matches the idle level and reset makes no false edge.
  eirq_sync #(.W(8)) u_sync_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (~ext_irq_pins),
    .dout    (ext_s_n)
  );
  assign ext_s = ~ext_s_n;
  eirq_sync #(.W(24)) u_sync_pc (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pin_change_inputs),
    .dout    (pc_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d <= 8'hFF;
      pc_d  <= 24'h000000;
    end else begin
      // Upper pins only advance their history while the I/O clock runs
      ext_d[3:0] <= ext_s[3:0];
      if (core_in.io_clk_run) begin
        ext_d[7:4] <= ext_s[7:4];
      end
      pc_d <= pc_s;
    end
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign sense_all = {sense_ctrl_high_pins, sense_ctrl_low_pins};

  // Edge decode per pin from its two-bit sense code
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (sense_all[2*i +: 2])
        SENSE_ANY:  edge_hit[i] = ext_s[i] ^ ext_d[i];
        SENSE_FALL: edge_hit[i] = !ext_s[i] && ext_d[i];
        SENSE_RISE: edge_hit[i] = ext_s[i] && !ext_d[i];
        default:    edge_hit[i] = 1'b0;
      endcase
      // Level mode is a live condition, not a flag; a level gone before
      // start-up leaves nothing behind.
      level_req[i] = (sense_all[2*i +: 2] == SENSE_LOW) && !ext_s[i];
    end
    if (!core_in.io_clk_run) begin
      edge_hit[7:4] = 4'h0;
    end
  end

  // Toggle of any masked-in input per group
  assign pc_hit[0] = |((pc_s[7:0]   ^ pc_d[7:0])   & pin_change_mask_zero);
  assign pc_hit[1] = |((pc_s[15:8]  ^ pc_d[15:8])  & pin_change_mask_one);
  assign pc_hit[2] = |((pc_s[23:16] ^ pc_d[23:16]) & pin_change_mask_two);

  // Vector base select and timed unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_base_select   <= 1'b0;
      vector_change_unlock <= 1'b0;
      unlock_cnt           <= 3'h0;
      block_tail           <= 1'b0;
    end else begin
      block_tail <= 1'b0;
      if (vector_change_unlock) begin
        unlock_cnt <= unlock_cnt + 3'h1;
      end
      if (wr && paddr == OFS_MCU_CONTROL) begin
        if (pwdata[BIT_UNLOCK]) begin
          vector_change_unlock <= 1'b1;
          unlock_cnt           <= 3'h1;
        end else if (vector_change_unlock) begin
          vector_base_select   <= pwdata[BIT_SELECT];
          vector_change_unlock <= 1'b0;
          block_tail           <= 1'b1;
        end
      end else if (vector_change_unlock && unlock_cnt == UNLOCK_LAST) begin
        vector_change_unlock <= 1'b0;
      end
    end
  end

  // Blocking never touches the core's global enable, only delivery
  assign irq_blocked = vector_change_unlock || block_tail;
  assign sect_mute = (vector_base_select && app_side_lock_bit && !core_in.pc_in_boot)
                  || (!vector_base_select && boot_side_lock_bit && core_in.pc_in_boot);

  always_comb begin
    case (boot_size_fuses)
      2'h0:    boot_base = BOOT_BASE_00;
      2'h1:    boot_base = BOOT_BASE_01;
      2'h2:    boot_base = BOOT_BASE_10;
      default: boot_base = BOOT_BASE_11;
    endcase
  end
  assign vec_base = vector_base_select ? boot_base : APP_BASE;

  // Flags: hardware set wins over an acknowledge or a one-write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_flag_reg <= RESET_BYTE;
      pc_flag          <= 3'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (sense_all[2*i +: 2] == SENSE_LOW) begin
          ext_irq_flag_reg[i] <= 1'b0;
        end else if (edge_hit[i]) begin
          ext_irq_flag_reg[i] <= 1'b1;
        end else if ((wr && paddr == OFS_FLAG && pwdata[i])
                     || (core_in.ack && core_in.ack_index == 6'(i + 1))) begin
          ext_irq_flag_reg[i] <= 1'b0;
        end
      end
      for (int g = 0; g < 3; g++) begin
        if (pc_hit[g]) begin
          pc_flag[g] <= 1'b1;
        end else if ((wr && paddr == OFS_PC_FLAG && pwdata[g])
                     || (core_in.ack && core_in.ack_index == VEC_PC0 + 6'(g))) begin
          pc_flag[g] <= 1'b0;
        end
      end
    end
  end

  // Plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_ctrl_low_pins  <= RESET_BYTE;
      sense_ctrl_high_pins <= RESET_BYTE;
      ext_irq_mask_reg     <= RESET_BYTE;
      pc_enable            <= 3'h0;
      pin_change_mask_zero <= RESET_BYTE;
      pin_change_mask_one  <= RESET_BYTE;
      pin_change_mask_two  <= RESET_BYTE;
    end else if (wr) begin
      case (paddr)
        OFS_SENSE_LOW:  sense_ctrl_low_pins  <= pwdata[7:0];
        OFS_SENSE_HIGH: sense_ctrl_high_pins <= pwdata[7:0];
        OFS_MASK:       ext_irq_mask_reg     <= pwdata[7:0];
        OFS_PC_CTRL:    pc_enable            <= pwdata[2:0];
        OFS_PC_MASK0:   pin_change_mask_zero <= pwdata[7:0];
        OFS_PC_MASK1:   pin_change_mask_one  <= pwdata[7:0];
        OFS_PC_MASK2:   pin_change_mask_two  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data registered in the setup cycle, so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (rd) begin
        case (paddr)
          OFS_MCU_CONTROL: prdata[1:0] <= {vector_base_select, vector_change_unlock};
          OFS_SENSE_LOW:   prdata[7:0] <= sense_ctrl_low_pins;
          OFS_SENSE_HIGH:  prdata[7:0] <= sense_ctrl_high_pins;
          OFS_MASK:        prdata[7:0] <= ext_irq_mask_reg;
          OFS_FLAG:        prdata[7:0] <= ext_irq_flag_reg;
          OFS_PC_CTRL:     prdata[2:0] <= pc_enable;
          OFS_PC_MASK0:    prdata[7:0] <= pin_change_mask_zero;
          OFS_PC_MASK1:    prdata[7:0] <= pin_change_mask_one;
          OFS_PC_MASK2:    prdata[7:0] <= pin_change_mask_two;
          OFS_PC_FLAG:     prdata[2:0] <= pc_flag;
          default:         pslverr <= 1'b1;
        endcase
      end else if (!(paddr inside {OFS_MCU_CONTROL, OFS_SENSE_LOW, OFS_SENSE_HIGH,
                                   OFS_MASK, OFS_FLAG, OFS_PC_CTRL, OFS_PC_MASK0,
                                   OFS_PC_MASK1, OFS_PC_MASK2, OFS_PC_FLAG})) begin
        pslverr <= 1'b1;
      end
    end
  end

  // Lowest index wins; delivery needs mask and global enable
  assign pending = {pc_flag & pc_enable,
                    (ext_irq_flag_reg | level_req) & ext_irq_mask_reg};
  always_comb begin
    next_valid = 1'b0;
    next_index = 6'h00;
    for (int k = 10; k >= 0; k--) begin
      if (pending[k]) begin
        next_valid = 1'b1;
        next_index = 6'(k + 1);
      end
    end
    if (!core_in.global_enable || irq_blocked || sect_mute) begin
      next_valid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req     <= '0;
      wake_request <= 1'b0;
      reset_vector <= APP_BASE;
    end else begin
      core_req.valid <= next_valid;
      core_req.index <= next_index;
      core_req.addr  <= vec_addr(vec_base, next_index);
      // Pin change, low level and low pin edges wake from any sleep
      wake_request   <= |pending[3:0] | |(level_req & ext_irq_mask_reg) | |pending[10:8];
      reset_vector   <= boot_reset_location_fuse ? boot_base : APP_BASE;
    end
  end

  unlock_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(vector_change_unlock) |-> ##[1:4] !vector_change_unlock)
    else $error("unlock bit held too long");
  unlock_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    vector_change_unlock |-> ##1 !core_req.valid)
    else $error("request delivered while unlocked");
  late_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_change_unlock && wr && paddr == OFS_MCU_CONTROL && !pwdata[BIT_UNLOCK])
      |=> $stable(vector_base_select))
    else $error("select changed outside window");
  base_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.valid |-> (core_req.addr[PC_W-1:7] == 10'h000) == !$past(vector_base_select)
      || boot_size_fuses != $past(boot_size_fuses))
    else $error("vector base wrong");
  global_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !core_in.global_enable |=> !core_req.valid)
    else $error("delivered without global enable");
  level_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sense_ctrl_low_pins[1:0] == SENSE_LOW) |=> !ext_irq_flag_reg[0])
    else $error("flag set in level mode");
  group_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_change_mask_zero == 8'h00 && !pc_flag[0]) |=> !pc_flag[0])
    else $error("masked group raised");
  high_edge_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!core_in.io_clk_run && !ext_irq_flag_reg[4] && sense_ctrl_high_pins[1:0] != SENSE_LOW)
      |=> !ext_irq_flag_reg[4])
    else $error("edge seen without io clock");
  boot_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_reset_location_fuse && boot_size_fuses == 2'h0) [*2] |=> reset_vector == 17'h1F000)
    else $error("reset vector wrong");

  // Blocking, section locks, level requests, flag set priority and group one
  tail_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_change_unlock && wr && paddr == OFS_MCU_CONTROL && !pwdata[BIT_UNLOCK])
      |-> ##2 !core_req.valid)
    else $error("request delivered right after select write");
  select_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_change_unlock && wr && paddr == OFS_MCU_CONTROL && !pwdata[BIT_UNLOCK])
      |=> !vector_change_unlock)
    else $error("unlock bit kept after select write");
  mute_app_a: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_base_select && app_side_lock_bit && !core_in.pc_in_boot) |=> !core_req.valid)
    else $error("request delivered in application section");
  mute_boot_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_base_select && boot_side_lock_bit && core_in.pc_in_boot) |=> !core_req.valid)
    else $error("request delivered in boot section");
  level_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(level_req & ext_irq_mask_reg) && core_in.global_enable && !irq_blocked && !sect_mute)
      |=> core_req.valid)
    else $error("level request dropped");
  level_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(level_req & ext_irq_mask_reg) |=> wake_request)
    else $error("level request gave no wake");
  flag_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_hit[0] && sense_ctrl_low_pins[1:0] != SENSE_LOW) |=> ext_irq_flag_reg[0])
    else $error("edge lost against a clear");
  group_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    |((pc_s[15:8] ^ pc_d[15:8]) & pin_change_mask_one) |=> pc_flag[1])
    else $error("group one toggle not flagged");
endmodule : eirq_top

// [verif/eirq_core_model.sv]
// Core-side model: takes delivered requests and enters their handlers
`timescale 1ns/1ps
module eirq_core_model (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Core state set by the bench
  input  wire logic                   global_enable,
  input  wire logic                   io_clk_run,
  input  wire logic                   pc_in_boot,
  // Request and answer
  input  wire eirq_pkg::eirq_req_type core_req,
  output eirq_pkg::eirq_core_type     core_in
);
  import eirq_pkg::*;
  logic       ack;
  logic [5:0] ack_index;
  // Global enable is owned here; the front end only reads it
  assign core_in = '{pc_in_boot: pc_in_boot, global_enable: global_enable,
                     io_clk_run: io_clk_run, ack: ack, ack_index: ack_index};
  // Handler entry one cycle after a request; a live level gets an ack every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack       <= 1'b0;
      ack_index <= 6'h00;
    end else begin
      ack       <= core_req.valid && !ack;
      ack_index <= core_req.index;
    end
  end
endmodule : eirq_core_model

// [verif/ext_irq_and_vector_relocation_test.sv]
// Self-checking bench for the interrupt front end
`timescale 1ns/1ps
module ext_irq_and_vector_relocation_test;
  import eirq_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                wake_request, ge, io_run, err, app_lock, boot_lock, in_boot;
  logic [ADDR_W-1:0]   paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic [7:0]          pins;
  logic [23:0]         pcin;
  logic [PC_W-1:0]     reset_vector;
  eirq_req_type        core_req;
  eirq_core_type       core_in;
  int                  errors = 0;
  int                  n_compared = 0;
  int                  cycles = 0;

  eirq_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pins(pins), .pin_change_inputs(pcin),
    .boot_size_fuses(2'h0), .boot_reset_location_fuse(1'b1), .app_side_lock_bit(app_lock),
    .boot_side_lock_bit(boot_lock), .core_in(core_in), .core_req(core_req),
    .wake_request(wake_request), .reset_vector(reset_vector));
  eirq_core_model core_u (.pclk(pclk), .presetn(presetn), .global_enable(ge),
    .io_clk_run(io_run), .pc_in_boot(in_boot), .core_req(core_req), .core_in(core_in));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (!(pready === 1'b1) && n < 50);
    if (n >= 50) errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_req(input logic [5:0] idx, input logic [PC_W-1:0] adr);
    int n;
    n = 0;
    while (!(core_req.valid === 1'b1) && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(core_req.valid), 32'h1);
    chk(32'(core_req.index), 32'(idx));
    chk(32'(core_req.addr), 32'(adr));
  endtask : wait_req

  task automatic no_req(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge pclk);
      if (core_req.valid !== 1'b0) seen = 1'b1;
    end
    chk(32'(seen), 32'h0);
  endtask : no_req

  // Mask off first so a sense change cannot raise a stray request
  task automatic arm(input logic [ADDR_W-1:0] core_status_reg, input logic [7:0] sense, input logic [7:0] m);
    wr(OFS_MASK, 32'h0);
    wr(core_status_reg, 32'(sense));
    wr(OFS_FLAG, 32'hFF);
    wr(OFS_MASK, 32'(m));
  endtask : arm

  task automatic t_regs();
    rdchk(OFS_MCU_CONTROL, 32'h0);
    wr(OFS_SENSE_HIGH, 32'hA5);
    rdchk(OFS_SENSE_HIGH, 32'hA5);
    wr(OFS_SENSE_HIGH, 32'h0);
    xfer(1'b0, 12'h0FC, 32'h0);
    chk(32'(err), 32'h1);
    chk(32'(reset_vector), 32'(BOOT_BASE_00));
  endtask : t_regs

  // Falling, rising and any-change codes on pins 0..2
  task automatic t_edges(input logic [PC_W-1:0] base);
    logic [1:0] code [3];
    logic       start [3];
    code  = '{SENSE_FALL, SENSE_RISE, SENSE_ANY};
    start = '{1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk) pins[k] <= start[k];
      arm(OFS_SENSE_LOW, 8'(code[k]) << (2 * k), 8'h1 << k);
      @(posedge pclk) pins[k] <= ~start[k];
      wait_req(6'(k + 1), base + PC_W'(2 * (k + 1)));
      wr(OFS_MASK, 32'h0);
      @(posedge pclk) pins[k] <= 1'b1;
    end
  endtask : t_edges

  task automatic t_flag();
    ge <= 1'b0;
    arm(OFS_SENSE_LOW, 8'(SENSE_FALL), 8'h01);
    @(posedge pclk) pins[0] <= 1'b0;
    no_req(8);
    chk(32'(wake_request), 32'h1);
    rdchk(OFS_FLAG, 32'h1);
    wr(OFS_FLAG, 32'h1);
    rdchk(OFS_FLAG, 32'h0);
    @(posedge pclk) pins[0] <= 1'b1;
    ge <= 1'b1;
  endtask : t_flag

  task automatic t_level();
    int hits;
    hits = 0;
    arm(OFS_SENSE_LOW, 8'h00, 8'h08);
    @(posedge pclk) pins[3] <= 1'b0;
    wait_req(6'h4, PC_W'(8));
    repeat (10) begin
      @(negedge pclk);
      if (core_req.valid === 1'b1) hits++;
    end
    chk(32'(hits >= 5), 32'h1);
    rdchk(OFS_FLAG, 32'h0);
    wr(OFS_MASK, 32'h0);
    @(posedge pclk) pins[3] <= 1'b1;
  endtask : t_level

  task automatic t_ioclk();
    io_run <= 1'b0;
    arm(OFS_SENSE_HIGH, 8'(SENSE_FALL), 8'h10);
    @(posedge pclk) pins[4] <= 1'b0;
    no_req(10);
    rdchk(OFS_FLAG, 32'h0);
    @(posedge pclk) pins[4] <= 1'b1;
    repeat (4) @(posedge pclk);
    io_run <= 1'b1;
    wr(OFS_MASK, 32'h0);
  endtask : t_ioclk

  // Per group: a masked-out input stays silent, a masked-in one requests
  task automatic t_pc();
    for (int g = 0; g < 3; g++) begin
      wr(OFS_PC_MASK0 + ADDR_W'(4 * g), 32'h2);
      wr(OFS_PC_FLAG, 32'h7);
      wr(OFS_PC_CTRL, 32'h1 << g);
      @(posedge pclk) pcin[8 * g] <= 1'b1;
      no_req(8);
      @(posedge pclk) pcin[8 * g + 1] <= 1'b1;
      wait_req(6'(9 + g), PC_W'(2 * (9 + g)));
      wr(OFS_PC_CTRL, 32'h0);
    end
  endtask : t_pc

  task automatic t_vec();
    wr(OFS_MCU_CONTROL, 32'h2);
    rdchk(OFS_MCU_CONTROL, 32'h0);
    wr(OFS_MCU_CONTROL, 32'h1);
    wr(OFS_MCU_CONTROL, 32'h2);
    rdchk(OFS_MCU_CONTROL, 32'h2);
    t_edges(BOOT_BASE_00);
    wr(OFS_MCU_CONTROL, 32'h1);
    repeat (6) @(posedge pclk);
    rdchk(OFS_MCU_CONTROL, 32'h2);
    wr(OFS_MCU_CONTROL, 32'h0);
    rdchk(OFS_MCU_CONTROL, 32'h2);
  endtask : t_vec

  // Unlock window and section locks hold back a live level request
  task automatic t_block();
    arm(OFS_SENSE_LOW, 8'h00, 8'h08);
    @(posedge pclk) pins[3] <= 1'b0;
    wait_req(6'h4, BOOT_BASE_00 + PC_W'(8));
    wr(OFS_MCU_CONTROL, 32'h1);
    @(negedge pclk);
    no_req(4);
    wait_req(6'h4, BOOT_BASE_00 + PC_W'(8));
    @(posedge pclk) app_lock <= 1'b1;
    @(negedge pclk);
    no_req(5);
    @(posedge pclk) in_boot <= 1'b1;
    wait_req(6'h4, BOOT_BASE_00 + PC_W'(8));
    @(posedge pclk) app_lock <= 1'b0;
    wr(OFS_MCU_CONTROL, 32'h1);
    wr(OFS_MCU_CONTROL, 32'h0);
    rdchk(OFS_MCU_CONTROL, 32'h0);
    @(posedge pclk) boot_lock <= 1'b1;
    @(negedge pclk);
    no_req(5);
    @(posedge pclk) in_boot <= 1'b0;
    wait_req(6'h4, APP_BASE + PC_W'(8));
    @(posedge pclk) boot_lock <= 1'b0;
    wr(OFS_MASK, 32'h0);
    @(posedge pclk) pins[3] <= 1'b1;
  endtask : t_block

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = 32'h0;
    pins    = 8'hFF;
    pcin    = 24'h0;
    ge      = 1'b1;
    io_run  = 1'b1;
    app_lock  = 1'b0;
    boot_lock = 1'b0;
    in_boot   = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_edges(APP_BASE);
    t_flag();
    t_level();
    t_ioclk();
    t_pc();
    t_vec();
    t_block();
    print_verdict();
  end
endmodule : ext_irq_and_vector_relocation_test
